// ---- core/recovered_clock_output_select.sv ----
// recovered clock output one: source, type and frequency select with squelch
// assumes per-port clocks are already sampled into clk_i as levels; squelch pin is async
`timescale 1ns/100ps
`include "recovered_clock_map.svh"

// Notes on behaviour
// [R1] output driven only when enable bit set
// [R2] port field picks source, codes above three reserved
// [R3] frequency field picks 25, 125, 31.25 MHz
// [R4] strict squelch: down, master/10M, EEE all low
// [R5] relaxed squelch also passes master/10M and LP_IDLE
// [R6] link-only squelch: low only when link down
// [R7] never squelch, clock passes with link down
// [R8] external squelch pin forces output low always
// [R9] type field picks serial, copper receive, transmit
// [R10] reserved bits read zero; reserved codes squelch
module recovered_clock_output_select #(
  parameter int PORTS = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  input  wire logic             we_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic                  ack_o,
  input  wire logic [PORTS-1:0] serial_clock_i,
  input  wire logic [PORTS-1:0] copper_receive_clock_i,
  input  wire logic [PORTS-1:0] copper_transmit_clock_i,
  input  wire logic [PORTS-1:0] link_up_i,
  input  wire logic [PORTS-1:0] link_unstable_i,
  input  wire logic [PORTS-1:0] master_or_10m_i,
  input  wire logic [PORTS-1:0] eee_mode_i,
  input  wire logic [PORTS-1:0] lp_idle_rx_i,
  input  wire logic             squelch_pin_i,
  output logic                  recovered_clock_out_one_o,
  output logic      [2:0]       output_frequency_o
);

  logic [15:0] control;
  logic [2:0]  squelch_sync;
  logic        squelch_pin;
  logic        clock_pass;
  logic        next_clock;

  localparam logic [15:0] write_mask = `RCK_CTRL_WMASK;

  function automatic logic clock_of(input logic [2:0] kind, input logic s, input logic r,
                                    input logic t);
    case (kind)
      3'h0:    clock_of = s;
      3'h1:    clock_of = r;
      default: clock_of = t;
    endcase
  endfunction

  wire logic [3:0] port_sel = control[`RCK_PORT_HI:`RCK_PORT_LO];
  wire logic [2:0] freq_sel = control[`RCK_FREQ_HI:`RCK_FREQ_LO];
  wire logic [2:0] type_sel = control[`RCK_TYPE_HI:`RCK_TYPE_LO];
  wire recovered_clock_pkg::squelch_level_t level =
    recovered_clock_pkg::squelch_level_t'(control[`RCK_SQL_HI:`RCK_SQL_LO]);
  wire logic [1:0] port_idx = port_sel[1:0];
  wire logic codes_ok = (port_sel <= `RCK_PORT_MAX) && (freq_sel <= `RCK_FREQ_MAX) &&
                        (type_sel <= `RCK_TYPE_MAX); // [R2] [R3] [R9] [R10]

  // wishbone slave, ack one cycle after strobe, dropped the cycle after
  wire logic req = cyc_i && stb_i && !ack_o;
  // a write lands on the edge at which the master samples ack high
  wire logic write_take = cyc_i && stb_i && we_i && ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= `RCK_CTRL_RESET; // [R1]
    end else if (write_take && adr_i == `RCK_CTRL_ADDR) begin
      if (sel_i[0]) begin
        control[7:0] <= dat_i[7:0] & write_mask[7:0]; // [R10]
      end
      if (sel_i[1]) begin
        control[15:8] <= dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      if (adr_i == `RCK_CTRL_ADDR) begin
        dat_o <= {16'h0000, control};
      end else if (adr_i == `RCK_STATUS_ADDR) begin
        dat_o <= {29'h0000_0000, squelch_pin, clock_pass, codes_ok};
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // squelch pin synchroniser; change counts when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      squelch_sync <= 3'h7;
      squelch_pin  <= 1'b1;
    end else begin
      squelch_sync <= {squelch_sync[1:0], squelch_pin_i};
      if (squelch_sync[1] == squelch_sync[2]) begin
        squelch_pin <= squelch_sync[2];
      end
    end
  end

  // squelch policy for the selected port
  always_comb begin
    case (level)
      recovered_clock_pkg::SQL_STRICT:
        clock_pass = link_up_i[port_idx] && !link_unstable_i[port_idx] &&
                     !master_or_10m_i[port_idx] && !eee_mode_i[port_idx]; // [R4]
      recovered_clock_pkg::SQL_RELAXED:
        clock_pass = link_up_i[port_idx] && !link_unstable_i[port_idx] &&
                     (!eee_mode_i[port_idx] || lp_idle_rx_i[port_idx]); // [R5]
      recovered_clock_pkg::SQL_LINK_ONLY:
        clock_pass = link_up_i[port_idx]; // [R6]
      default:
        clock_pass = 1'b1; // [R7]
    endcase
  end

  always_comb begin
    next_clock = 1'b0;
    if (control[`RCK_ENABLE_BIT] && !squelch_pin && codes_ok && clock_pass) begin // [R1] [R8]
      next_clock = clock_of(type_sel, serial_clock_i[port_idx], copper_receive_clock_i[port_idx],
                            copper_transmit_clock_i[port_idx]); // [R9] [R2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recovered_clock_out_one_o <= 1'b0;
      output_frequency_o        <= 3'h0;
    end else begin
      recovered_clock_out_one_o <= next_clock;
      output_frequency_o        <= freq_sel; // [R3]
    end
  end

  sql_pin_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    squelch_pin |=> !recovered_clock_out_one_o)
    else $error("clock output not squelched by pin");
  enable_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    !control[`RCK_ENABLE_BIT] |=> !recovered_clock_out_one_o)
    else $error("clock output driven while disabled");
  port_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (port_sel > `RCK_PORT_MAX) |=> !recovered_clock_out_one_o)
    else $error("reserved port passed clock");
  freq_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    ##1 output_frequency_o == $past(freq_sel))
    else $error("frequency select not followed");
  strict_sql_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (level == recovered_clock_pkg::SQL_STRICT && eee_mode_i[port_idx])
      |=> !recovered_clock_out_one_o)
    else $error("strict squelch passed eee clock");
  relaxed_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (level == recovered_clock_pkg::SQL_RELAXED && link_up_i[port_idx] &&
     !link_unstable_i[port_idx] && master_or_10m_i[port_idx] && !eee_mode_i[port_idx])
      |-> clock_pass)
    else $error("relaxed squelch blocked master clock");
  link_only_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (level == recovered_clock_pkg::SQL_LINK_ONLY && !link_up_i[port_idx])
      |=> !recovered_clock_out_one_o)
    else $error("link-only squelch passed clock with link down");
  never_sql_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (level == recovered_clock_pkg::SQL_NEVER && control[`RCK_ENABLE_BIT] && !squelch_pin &&
     codes_ok && type_sel == 3'h0)
      |=> recovered_clock_out_one_o == $past(serial_clock_i[port_idx]))
    else $error("never squelch blocked clock");
  type_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (control[`RCK_ENABLE_BIT] && !squelch_pin && codes_ok && clock_pass && type_sel == 3'h2)
      |=> recovered_clock_out_one_o == $past(copper_transmit_clock_i[port_idx]))
    else $error("transmit clock not selected");
  rsvd_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    control[7:6] == 2'h0 && !control[3])
    else $error("reserved control bits set");
  strict_down_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (level == recovered_clock_pkg::SQL_STRICT && !link_up_i[port_idx])
      |=> !recovered_clock_out_one_o)
    else $error("strict squelch passed clock with link down");
  strict_master_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (level == recovered_clock_pkg::SQL_STRICT && master_or_10m_i[port_idx])
      |=> !recovered_clock_out_one_o)
    else $error("strict squelch passed master clock");
  relaxed_lpi_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (level == recovered_clock_pkg::SQL_RELAXED && control[`RCK_ENABLE_BIT] && !squelch_pin &&
     codes_ok && type_sel == 3'h0 && link_up_i[port_idx] && !link_unstable_i[port_idx] &&
     eee_mode_i[port_idx] && lp_idle_rx_i[port_idx])
      |=> recovered_clock_out_one_o == $past(serial_clock_i[port_idx]))
    else $error("relaxed squelch blocked clock during lp idle");
  relaxed_eee_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (level == recovered_clock_pkg::SQL_RELAXED && eee_mode_i[port_idx] && !lp_idle_rx_i[port_idx])
      |=> !recovered_clock_out_one_o)
    else $error("relaxed squelch passed eee clock");
  freq_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (freq_sel > `RCK_FREQ_MAX) |=> !recovered_clock_out_one_o)
    else $error("reserved frequency passed clock");
  type_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (type_sel > `RCK_TYPE_MAX) |=> !recovered_clock_out_one_o)
    else $error("reserved clock type passed clock");
  receive_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    (control[`RCK_ENABLE_BIT] && !squelch_pin && codes_ok && clock_pass && type_sel == 3'h1)
      |=> recovered_clock_out_one_o == $past(copper_receive_clock_i[port_idx]))
    else $error("copper receive clock not selected");
  rsvd_bus_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    (req && !we_i && adr_i == `RCK_CTRL_ADDR)
      |=> (dat_o[7:6] == 2'h0 && !dat_o[3]))
    else $error("reserved control bits read as one");

endmodule // recovered_clock_output_select

// ---- shared/recovered_clock_map.svh ----
// register offsets, fields and reset values of the recovered clock control block
// assumes a wishbone byte address with one 32-bit word per register
`ifndef RECOVERED_CLOCK_MAP_SVH
`define RECOVERED_CLOCK_MAP_SVH
`define RCK_CTRL_INDEX     8'h17
`define RCK_CTRL_ADDR      8'h5C
`define RCK_STATUS_ADDR    8'h60
`define RCK_ENABLE_BIT     15
`define RCK_PORT_HI        14
`define RCK_PORT_LO        11
`define RCK_FREQ_HI        10
`define RCK_FREQ_LO        8
`define RCK_SQL_HI         5
`define RCK_SQL_LO         4
`define RCK_TYPE_HI        2
`define RCK_TYPE_LO        0
`define RCK_CTRL_RESET     16'h0000
`define RCK_CTRL_WMASK     16'hFF37
`define RCK_PORT_MAX       4'h3
`define RCK_FREQ_MAX       3'h2
`define RCK_TYPE_MAX       3'h2
`endif

// ---- shared/recovered_clock_pkg.sv ----
// types shared by the recovered clock output select block
package recovered_clock_pkg;
  typedef enum logic [1:0] {
    SQL_STRICT,
    SQL_RELAXED,
    SQL_LINK_ONLY,
    SQL_NEVER
  } squelch_level_t;

  typedef enum logic [1:0] {
    LINK_DOWN,
    LINK_UNSTABLE,
    LINK_UP
  } link_state_t;
endpackage

// ---- sim/clock_sink_model.sv ----
// partner model: timing logic that consumes recovered clock one and counts its rising edges
// assumes the clock level is sampled on clk_i of the device
`timescale 1ns/100ps
module clock_sink_model (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic       rck_i,
  output logic      [7:0] edges_o
);
  logic last;
  always_ff @(posedge clk_i) begin
    last    <= rck_i;
    edges_o <= clr_i ? 8'h00 : edges_o + {7'h00, rck_i & ~last};
  end
endmodule // clock_sink_model

// ---- sim/tb_top.sv ----
// self-checking bench for the recovered clock output select block
// assumes the wishbone slave acks one cycle after taking a request
`timescale 1ns/100ps
`include "recovered_clock_map.svh"
module tb_top;
  logic        clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
  logic        squelch_pin_i = 1'h0, tog = 1'h0, clr = 1'h1, ack_o, recovered_clock_out_one_o;
  logic [7:0]  adr_i = 8'h00, edges;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0]  sel_i = 4'hF, ms = 4'h0, mr = 4'h0, mt = 4'h0, up = 4'h0, un = 4'h0;
  logic [3:0]  m10 = 4'h0, eee = 4'h0, lpi = 4'h0;
  logic [2:0]  output_frequency_o;
  logic [4:0]  st [6] = '{5'h10, 5'h00, 5'h14, 5'h12, 5'h13, 5'h18};
  logic [3:0]  ex [6] = '{4'hF, 4'h8, 4'hE, 4'hC, 4'hE, 4'hC};
  int          fails = 0, compares = 0, p, t;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) tog <= ~tog;
  recovered_clock_output_select i_dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
    .cyc_i, .stb_i, .ack_o, .serial_clock_i({4{tog}} & ms), .copper_receive_clock_i({4{tog}} & mr),
    .copper_transmit_clock_i({4{tog}} & mt), .link_up_i(up), .link_unstable_i(un),
    .master_or_10m_i(m10), .eee_mode_i(eee), .lp_idle_rx_i(lpi), .squelch_pin_i,
    .recovered_clock_out_one_o, .output_frequency_o);
  clock_sink_model i_sink (.clk_i, .clr_i(clr), .rck_i(recovered_clock_out_one_o), .edges_o(edges));
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && n < 20);
    if (ack_o !== 1'h1) begin
      fails++;
      close_out();
    end
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    we_i  <= 1'h0;
  endtask
  task automatic wr(input logic e, input logic [3:0] q, input logic [2:0] f, input logic [1:0] s,
                    input logic [2:0] y);
    bus(1'h1, `RCK_CTRL_ADDR, {16'h0000, e, q, f, 2'h0, s, 1'h0, y});
  endtask
  // clock present at the sink over a 16-cycle window
  task automatic meas(input logic on);
    repeat (6) @(posedge clk_i);
    clr <= 1'h1;
    @(posedge clk_i);
    clr <= 1'h0;
    repeat (16) @(posedge clk_i);
    chk(edges != 8'h00, on);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    bus(1'h0, `RCK_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk(output_frequency_o, 3'h0);
    bus(1'h0, `RCK_STATUS_ADDR, 32'h0);
    chk(rd, 32'h1);
    ms <= 4'hF;
    mr <= 4'hF;
    up <= 4'hF;
    meas(1'h0);
    bus(1'h1, `RCK_CTRL_ADDR, 32'hFFFF);
    bus(1'h0, `RCK_CTRL_ADDR, 32'h0);
    chk(rd, 32'hFF37);
    meas(1'h0);
    wr(1'h1, 4'h0, 3'h0, 2'h3, 3'h3);
    meas(1'h0);
    bus(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    up <= 4'h0;
    for (p = 0; p < 4; p++) for (t = 0; t < 3; t++) begin
      ms <= (t == 0) ? 4'h1 << p : 4'h0;
      mr <= (t == 1) ? 4'h1 << p : 4'h0;
      mt <= (t == 2) ? 4'h1 << p : 4'h0;
      wr(1'h1, p[3:0], 3'h0, 2'h3, t[2:0]);
      meas(1'h1);
      wr(1'h1, p[3:0] ^ 4'h1, 3'h0, 2'h3, t[2:0]);
      meas(1'h0);
    end
    for (t = 0; t < 3; t++) begin
      wr(1'h1, 4'h0, t[2:0], 2'h3, 3'h0);
      repeat (3) @(posedge clk_i);
      chk(output_frequency_o, t[2:0]);
    end
    ms <= 4'hF;
    wr(1'h1, 4'h4, 3'h0, 2'h3, 3'h0);
    meas(1'h0);
    wr(1'h1, 4'h0, 3'h3, 2'h3, 3'h0);
    meas(1'h0);
    for (t = 0; t < 6; t++) for (p = 0; p < 4; p++) begin
      up  <= {4{st[t][4]}};
      un  <= {4{st[t][3]}};
      m10 <= {4{st[t][2]}};
      eee <= {4{st[t][1]}};
      lpi <= {4{st[t][0]}};
      wr(1'h1, 4'h0, 3'h0, p[1:0], 3'h0);
      meas(ex[t][p]);
    end
    squelch_pin_i <= 1'h1;
    meas(1'h0);
    squelch_pin_i <= 1'h0;
    meas(1'h1);
    wr(1'h0, 4'h0, 3'h0, 2'h3, 3'h0);
    meas(1'h0);
    close_out();
  end
endmodule // tb_top
